// file: mdh_digest_unit.sv
// Decided for this implementation: the address map and the APB register port.
`default_nettype none
module mdh_digest_unit (
    // Clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Interrupt
    output logic o_irq_n
);
    typedef struct packed {
        mdh_pkg::mdh_phase_t phase;
        mdh_pkg::mdh_alg_t alg;
        logic [6:0] rnd;
        logic [15:0][31:0] msg;
        logic [15:0][31:0] w;
        logic [4:0][31:0] dig;
        logic [4:0][31:0] v;
        logic [15:0] mask;
        logic pend;
        logic [11:0] ctrl;
        logic done;
        logic be;
        logic ae;
        logic irq;
        logic irq_n;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mdh_state_t;

    mdh_state_t s_reg;
    mdh_state_t s_next;

    function automatic logic [31:0] rotl(
        input logic [31:0] x,
        input logic [4:0] sh
    );
        return (x << sh) | (x >> (6'd32 - {1'b0, sh}));
    endfunction

    function automatic logic [31:0] bswap(input logic [31:0] x);
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction

    function automatic mdh_state_t rst_state();
        mdh_state_t r;
        r = '0;
        r.dig = mdh_pkg::MDH_IV;
        r.ctrl = mdh_pkg::MDH_CTRL_RST;
        r.irq_n = 1'b1;
        return r;
    endfunction

    // Second block of a keyed hash: old digest, then length padding
    function automatic logic [15:0][31:0] outer_pad_bit_blk(
        input logic [4:0][31:0] dg,
        input logic sha
    );
        logic [15:0][31:0] b;
        b = '0;
        for (int j = 0; j < 4; j++) begin
            b[j] = dg[j];
        end
        if (sha) begin
            b[4] = dg[4];
            b[5] = mdh_pkg::MDH_PAD_SHA;
            b[15] = mdh_pkg::MDH_LEN_SHA;
        end else begin
            b[4] = mdh_pkg::MDH_PAD_MD;
            b[14] = mdh_pkg::MDH_LEN_MD;
        end
        return b;
    endfunction

    logic [9:0] widx;
    logic [9:0] midx;
    logic [9:0] didx;
    logic setup;
    logic acc;
    logic wr;
    logic valid;
    logic hit_msg;
    logic hit_dig;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_clri;
    logic go;
    logic srst;
    logic step_ok;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] va;
    logic [31:0] vb;
    logic [31:0] vc;
    logic [31:0] vd;
    logic [31:0] ve;
    logic [31:0] ch;
    logic [31:0] par;
    logic [31:0] mj;
    logic [3:0] ri;
    logic [1:0] rg;
    logic [3:0] mi;
    logic [4:0] sh;
    logic [31:0] fv;
    logic [31:0] kv;
    logic [31:0] tv;
    logic [31:0] wn;
    logic [4:0][31:0] nv;
    logic [6:0] last;
    logic [11:0] nctrl;
    mdh_pkg::mdh_alg_t nalg;

    // Zero wait state slave: the answer is built in the setup cycle
    assign setup = i_psel & ~i_penable;
    assign acc = i_psel & i_penable & s_reg.pready;
    assign wr = acc & i_pwrite;
    assign widx = i_paddr[11:2];
    assign midx = widx - mdh_pkg::MDH_MSG_OFS[11:2];
    assign didx = widx - mdh_pkg::MDH_DIG_OFS[11:2];
    assign hit_msg = widx < mdh_pkg::MDH_DIG_OFS[11:2];
    assign hit_dig = ~hit_msg & (widx < mdh_pkg::MDH_CTRL_OFS[11:2]);
    assign hit_ctrl = widx == mdh_pkg::MDH_CTRL_OFS[11:2];
    assign hit_stat = widx == mdh_pkg::MDH_STAT_OFS[11:2];
    assign hit_clri = widx == mdh_pkg::MDH_CLRI_OFS[11:2];
    assign valid = widx <= mdh_pkg::MDH_CLRI_OFS[11:2];
    assign go = wr & hit_ctrl & i_pwdata[mdh_pkg::MDH_C_GO];
    assign srst = wr & hit_ctrl & i_pwdata[mdh_pkg::MDH_C_RST];
    assign step_ok = ~s_reg.ctrl[mdh_pkg::MDH_C_STEP] | go;
    assign wdat = i_pwdata
        ^ (s_reg.ctrl[mdh_pkg::MDH_C_INNER_PAD_BIT] ? mdh_pkg::MDH_INNER_PAD_BIT : 32'h0)
        ^ (s_reg.ctrl[mdh_pkg::MDH_C_OUTER_PAD_BIT] ? mdh_pkg::MDH_OUTER_PAD_BIT : 32'h0);
    assign va = s_reg.v[0];
    assign vb = s_reg.v[1];
    assign vc = s_reg.v[2];
    assign vd = s_reg.v[3];
    assign ve = s_reg.v[4];
    assign ch = (vb & vc) | (~vb & vd);
    assign par = vb ^ vc ^ vd;
    assign mj = (vb & vc) | (vb & vd) | (vc & vd);
    assign nctrl = (wr & hit_ctrl)
        ? (i_pwdata[11:0] & mdh_pkg::MDH_CTRL_STATIC) : s_reg.ctrl;

    // Algorithm chosen from the control value after this cycle's write
    always_comb begin
        if (nctrl[mdh_pkg::MDH_C_MD5]) begin
            nalg = mdh_pkg::MDH_ALG_MD5;
        end else if (nctrl[mdh_pkg::MDH_C_MD4]) begin
            nalg = mdh_pkg::MDH_ALG_MD4;
        end else begin
            nalg = mdh_pkg::MDH_ALG_SHA;
        end
    end

    // One round of the latched algorithm
    always_comb begin
        ri = s_reg.rnd[3:0];
        rg = s_reg.rnd[5:4];
        mi = ri;
        sh = 5'd0;
        fv = 32'h0;
        kv = 32'h0;
        tv = 32'h0;
        wn = s_reg.w[ri];
        nv = s_reg.v;
        last = mdh_pkg::MDH_LAST_SHA;
        case (s_reg.alg)
            mdh_pkg::MDH_ALG_MD5: begin
                last = mdh_pkg::MDH_LAST_MD5;
                case (rg)
                    2'd0: begin
                        fv = ch;
                    end
                    2'd1: begin
                        fv = (vd & vb) | (~vd & vc);
                        mi = ri * 4'd5 + 4'd1;
                    end
                    2'd2: begin
                        fv = par;
                        mi = ri * 4'd3 + 4'd5;
                    end
                    default: begin
                        fv = vc ^ (vb | ~vd);
                        mi = ri * 4'd7;
                    end
                endcase
                sh = mdh_pkg::MDH_MD5_S[{rg, ri[1:0]}];
                kv = mdh_pkg::MDH_MD5_K[s_reg.rnd[5:0]];
                tv = vb + rotl(va + fv + kv + s_reg.w[mi], sh);
                nv[0] = vd;
                nv[1] = tv;
                nv[2] = vb;
                nv[3] = vc;
            end
            mdh_pkg::MDH_ALG_MD4: begin
                last = mdh_pkg::MDH_LAST_MD4;
                case (rg)
                    2'd0: begin
                        fv = ch;
                    end
                    2'd1: begin
                        fv = mj;
                        kv = mdh_pkg::MDH_SHA_K[0];
                        mi = {ri[1:0], ri[3:2]};
                    end
                    default: begin
                        fv = par;
                        kv = mdh_pkg::MDH_SHA_K[1];
                        mi = {ri[0], ri[1], ri[2], ri[3]};
                    end
                endcase
                sh = mdh_pkg::MDH_MD4_S[{rg, ri[1:0]}];
                tv = rotl(va + fv + kv + s_reg.w[mi], sh);
                nv[0] = vd;
                nv[1] = tv;
                nv[2] = vb;
                nv[3] = vc;
            end
            default: begin
                // Schedule reuses the working copy as a 16-word ring
                if (s_reg.rnd >= mdh_pkg::MDH_SHA_SCHED) begin
                    wn = rotl(s_reg.w[ri + 4'd13] ^ s_reg.w[ri + 4'd8]
                        ^ s_reg.w[ri + 4'd2] ^ s_reg.w[ri], 5'd1);
                end
                if (s_reg.rnd < mdh_pkg::MDH_SHA_G1) begin
                    fv = ch;
                    kv = mdh_pkg::MDH_SHA_K[0];
                end else if (s_reg.rnd < mdh_pkg::MDH_SHA_G2) begin
                    fv = par;
                    kv = mdh_pkg::MDH_SHA_K[1];
                end else if (s_reg.rnd < mdh_pkg::MDH_SHA_G3) begin
                    fv = mj;
                    kv = mdh_pkg::MDH_SHA_K[2];
                end else begin
                    fv = par;
                    kv = mdh_pkg::MDH_SHA_K[3];
                end
                tv = rotl(va, 5'd5) + fv + ve + kv + wn;
                nv[0] = tv;
                nv[1] = va;
                nv[2] = rotl(vb, 5'd30);
                nv[3] = vc;
                nv[4] = vd;
            end
        endcase
    end

    // Read data, sampled in the setup cycle
    always_comb begin
        rdat = 32'h0;
        if (hit_dig) begin
            rdat = s_reg.dig[didx[2:0]];
            if (s_reg.ctrl[mdh_pkg::MDH_C_DIGEST_BYTE_SWAP]) begin
                rdat = bswap(rdat);
            end
        end else if (hit_ctrl) begin
            rdat = {20'h0, s_reg.ctrl};
        end else if (hit_stat) begin
            rdat[mdh_pkg::MDH_S_DONE] = s_reg.done;
            rdat[mdh_pkg::MDH_S_BE] = s_reg.be;
            rdat[mdh_pkg::MDH_S_AE] = s_reg.ae;
            rdat[mdh_pkg::MDH_S_IRQ] = s_reg.irq;
        end
    end

    always_comb begin
        s_next = s_reg;
        if (wr & hit_msg) begin
            s_next.msg[midx[3:0]] = wdat;
            s_next.mask[midx[3:0]] = 1'b1;
        end
        // Digest words are only writable while idle
        if (wr & hit_dig & (s_reg.phase == mdh_pkg::MDH_IDLE)) begin
            s_next.dig[didx[2:0]] = i_pwdata;
        end
        if (wr & hit_ctrl) begin
            s_next.ctrl = i_pwdata[11:0] & mdh_pkg::MDH_CTRL_STATIC;
        end
        // Clears come first so that a same-cycle set wins
        if (wr & hit_stat) begin
            s_next.done = 1'b0;
            s_next.be = 1'b0;
            s_next.ae = 1'b0;
        end
        if (wr & hit_clri) begin
            s_next.done = 1'b0;
            s_next.be = 1'b0;
        end
        if (acc & ~valid) begin
            s_next.ae = 1'b1;
        end
        if ((s_reg.phase != mdh_pkg::MDH_IDLE) & (&s_next.mask)) begin
            s_next.pend = 1'b1;
            s_next.mask = '0;
        end
        case (s_reg.phase)
            mdh_pkg::MDH_IDLE: begin
                if (go | s_reg.pend
                    | (nctrl[mdh_pkg::MDH_C_AUTO_START_BIT] & (&s_next.mask))) begin
                    s_next.phase = mdh_pkg::MDH_RUN;
                    s_next.rnd = 7'd0;
                    s_next.alg = nalg;
                    s_next.w = s_next.msg;
                    s_next.v = s_reg.dig;
                    s_next.mask = '0;
                    s_next.pend = 1'b0;
                    s_next.be = 1'b1;
                    if (nctrl[mdh_pkg::MDH_C_OUTER_PAD_BIT]) begin
                        s_next.msg = outer_pad_bit_blk(s_reg.dig,
                            nalg == mdh_pkg::MDH_ALG_SHA);
                        s_next.pend = 1'b1;
                    end
                end
            end
            mdh_pkg::MDH_RUN: begin
                if (step_ok) begin
                    s_next.v = nv;
                    s_next.w[ri] = wn;
                    s_next.rnd = s_reg.rnd + 7'd1;
                    if (s_reg.rnd == last) begin
                        s_next.phase = mdh_pkg::MDH_FOLD;
                    end
                end
            end
            mdh_pkg::MDH_FOLD: begin
                for (int j = 0; j < 5; j++) begin
                    s_next.dig[j] = s_reg.dig[j] + s_reg.v[j];
                end
                s_next.done = 1'b1;
                s_next.ctrl[mdh_pkg::MDH_C_OUTER_PAD_BIT] = 1'b0;
                s_next.ctrl[mdh_pkg::MDH_C_INNER_PAD_BIT] = 1'b0;
                s_next.phase = mdh_pkg::MDH_IDLE;
            end
            default: begin
                s_next.phase = mdh_pkg::MDH_IDLE;
            end
        endcase
        s_next.irq = s_next.ctrl[mdh_pkg::MDH_C_IE]
            & (s_next.done
            | (s_next.be & s_next.ctrl[mdh_pkg::MDH_C_BIE]));
        s_next.irq_n = ~s_next.irq;
        if (srst) begin
            s_next = rst_state();
        end
        s_next.pready = setup;
        s_next.pslverr = setup & ~valid;
        if (setup) begin
            s_next.prdata = rdat;
        end
    end

    // Clock enable freezes the bus answer too; keep it high during transfers
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= rst_state();
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end

    assign o_prdata = s_reg.prdata;
    assign o_pready = s_reg.pready;
    assign o_pslverr = s_reg.pslverr;
    assign o_irq_n = s_reg.irq_n;
endmodule
`default_nettype wire

// file: mdh_digest_unit_sva.sv
`default_nettype none
module mdh_digest_unit_sva (
    // Clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Interrupt
    input wire logic o_irq_n
);
    logic setup;
    logic rd_setup;
    logic wr_ctrl;
    logic ie_reg;
    logic ie_next;
    assign setup = i_psel && !i_penable && i_ce;
    assign rd_setup = setup && !i_pwrite;
    assign wr_ctrl = i_psel && i_penable && o_pready && i_pwrite && i_ce &&
        i_paddr[11:2] == mdh_pkg::MDH_CTRL_OFS[11:2];
    // Shadow of the global enable; soft reset clears the real one
    always_comb begin
        ie_next = ie_reg;
        if (wr_ctrl) begin
            ie_next = i_pwdata[mdh_pkg::MDH_C_IE] &&
                !i_pwdata[mdh_pkg::MDH_C_RST];
        end
    end
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ie_reg <= 1'b0;
        end else begin
            ie_reg <= ie_next;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    property p_unmapped_err;
        setup && i_paddr >= 12'h060 |=> o_pready && o_pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access not refused");
    property p_mapped_ok;
        setup && i_paddr < 12'h060 |=> o_pready && !o_pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok)
        else $error("mapped access refused");
    property p_unmapped_rd0;
        rd_setup && i_paddr >= 12'h060 |=> o_prdata == 32'h0;
    endproperty
    a_unmapped_rd0: assert property (p_unmapped_rd0)
        else $error("unmapped read not zero");
    property p_ctrl_rd;
        rd_setup && i_paddr[11:2] == mdh_pkg::MDH_CTRL_OFS[11:2] |=>
            o_prdata[31:12] == 20'h0 && !o_prdata[3] && !o_prdata[5] &&
            !o_prdata[0];
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd)
        else $error("control pulse or unused bit reads one");
    property p_stat_rd;
        rd_setup && i_paddr[11:2] == mdh_pkg::MDH_STAT_OFS[11:2] |=>
            o_prdata[31:4] == 28'h0;
    endproperty
    a_stat_rd: assert property (p_stat_rd)
        else $error("status unused bits set");
    property p_irq_gate;
        !ie_reg && !$past(ie_reg) |-> o_irq_n;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt active while disabled");
    property p_irq_src;
        $fell(o_irq_n) |-> ie_reg || ie_next;
    endproperty
    a_irq_src: assert property (p_irq_src)
        else $error("interrupt raised without enable");
    property p_srst;
        wr_ctrl && i_pwdata[mdh_pkg::MDH_C_RST] |=> o_irq_n [*3];
    endproperty
    a_srst: assert property (p_srst)
        else $error("interrupt survives soft reset");
endmodule
bind mdh_digest_unit mdh_digest_unit_sva u_sva (.i_clock(i_clock),
    .i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_irq_n(o_irq_n));
`default_nettype wire

// file: mdh_host.sv
`default_nettype none
module mdh_host (
    // Clock
    input wire logic i_clock,
    // APB master
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [11:0] o_paddr,
    output logic [31:0] o_pwdata,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    bit hung = 1'b0;
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 12'h000;
        o_pwdata = 32'h0;
    end
    // Request held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge i_clock);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clock);
        o_penable <= 1'b1;
        // Sampled at the rising edge, before this edge's updates land
        @(posedge i_clock);
        while (i_pready !== 1'b1 && n < 16) begin
            @(posedge i_clock);
            n++;
        end
        hung = hung || i_pready !== 1'b1;
        q = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // Released data no longer shows the old value
        o_pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// file: mdh_pkg.sv
`default_nettype none
package mdh_pkg;
    // Byte offsets of the register file
    localparam logic [11:0] MDH_MSG_OFS = 12'h000;
    localparam logic [11:0] MDH_DIG_OFS = 12'h040;
    localparam logic [11:0] MDH_CTRL_OFS = 12'h054;
    localparam logic [11:0] MDH_STAT_OFS = 12'h058;
    localparam logic [11:0] MDH_CLRI_OFS = 12'h05c;
    // Control bit positions
    localparam int MDH_C_STEP = 1;
    localparam int MDH_C_DIGEST_BYTE_SWAP = 2;
    localparam int MDH_C_GO = 3;
    localparam int MDH_C_IE = 4;
    localparam int MDH_C_RST = 5;
    localparam int MDH_C_MD4 = 6;
    localparam int MDH_C_MD5 = 7;
    localparam int MDH_C_BIE = 8;
    localparam int MDH_C_INNER_PAD_BIT = 9;
    localparam int MDH_C_OUTER_PAD_BIT = 10;
    localparam int MDH_C_AUTO_START_BIT = 11;
    localparam logic [11:0] MDH_CTRL_STATIC = 12'hfd6;
    localparam logic [11:0] MDH_CTRL_RST = 12'h000;
    // Status bit positions
    localparam int MDH_S_DONE = 0;
    localparam int MDH_S_BE = 1;
    localparam int MDH_S_AE = 2;
    localparam int MDH_S_IRQ = 3;
    // Keyed hash pads
    localparam logic [31:0] MDH_INNER_PAD_BIT = 32'h36363636;
    localparam logic [31:0] MDH_OUTER_PAD_BIT = 32'h5c5c5c5c;
    // Second block padding after the copied digest
    localparam logic [31:0] MDH_PAD_SHA = 32'h80000000;
    localparam logic [31:0] MDH_PAD_MD = 32'h00000080;
    localparam logic [31:0] MDH_LEN_SHA = 32'h000002a0;
    localparam logic [31:0] MDH_LEN_MD = 32'h00000280;
    // Digest value after reset
    localparam logic [4:0][31:0] MDH_IV = {32'hc3d2e1f0, 32'h10325476,
        32'h98badcfe, 32'hefcdab89, 32'h67452301};
    // Round counts
    localparam logic [6:0] MDH_LAST_MD4 = 7'd47;
    localparam logic [6:0] MDH_LAST_MD5 = 7'd63;
    localparam logic [6:0] MDH_LAST_SHA = 7'd79;
    localparam logic [6:0] MDH_SHA_SCHED = 7'd16;
    localparam logic [6:0] MDH_SHA_G1 = 7'd20;
    localparam logic [6:0] MDH_SHA_G2 = 7'd40;
    localparam logic [6:0] MDH_SHA_G3 = 7'd60;
    localparam logic [3:0][31:0] MDH_SHA_K = {32'hca62c1d6, 32'h8f1bbcdc,
        32'h6ed9eba1, 32'h5a827999};
    localparam logic [4:0] MDH_MD5_S [16] = '{5'd7, 5'd12, 5'd17, 5'd22,
        5'd5, 5'd9, 5'd14, 5'd20, 5'd4, 5'd11, 5'd16, 5'd23,
        5'd6, 5'd10, 5'd15, 5'd21};
    localparam logic [4:0] MDH_MD4_S [16] = '{5'd3, 5'd7, 5'd11, 5'd19,
        5'd3, 5'd5, 5'd9, 5'd13, 5'd3, 5'd9, 5'd11, 5'd15,
        5'd0, 5'd0, 5'd0, 5'd0};
    localparam logic [31:0] MDH_MD5_K [64] = '{
        32'hd76aa478, 32'he8c7b756, 32'h242070db, 32'hc1bdceee,
        32'hf57c0faf, 32'h4787c62a, 32'ha8304613, 32'hfd469501,
        32'h698098d8, 32'h8b44f7af, 32'hffff5bb1, 32'h895cd7be,
        32'h6b901122, 32'hfd987193, 32'ha679438e, 32'h49b40821,
        32'hf61e2562, 32'hc040b340, 32'h265e5a51, 32'he9b6c7aa,
        32'hd62f105d, 32'h02441453, 32'hd8a1e681, 32'he7d3fbc8,
        32'h21e1cde6, 32'hc33707d6, 32'hf4d50d87, 32'h455a14ed,
        32'ha9e3e905, 32'hfcefa3f8, 32'h676f02d9, 32'h8d2a4c8a,
        32'hfffa3942, 32'h8771f681, 32'h6d9d6122, 32'hfde5380c,
        32'ha4beea44, 32'h4bdecfa9, 32'hf6bb4b60, 32'hbebfbc70,
        32'h289b7ec6, 32'heaa127fa, 32'hd4ef3085, 32'h04881d05,
        32'hd9d4d039, 32'he6db99e5, 32'h1fa27cf8, 32'hc4ac5665,
        32'hf4292244, 32'h432aff97, 32'hab9423a7, 32'hfc93a039,
        32'h655b59c3, 32'h8f0ccc92, 32'hffeff47d, 32'h85845dd1,
        32'h6fa87e4f, 32'hfe2ce6e0, 32'ha3014314, 32'h4e0811a1,
        32'hf7537e82, 32'hbd3af235, 32'h2ad7d2bb, 32'heb86d391};
    typedef enum logic [1:0] {
        MDH_ALG_SHA = 2'd0,
        MDH_ALG_MD5 = 2'd1,
        MDH_ALG_MD4 = 2'd2
    } mdh_alg_t;
    typedef enum logic [1:0] {
        MDH_IDLE = 2'b00,
        MDH_RUN = 2'b01,
        MDH_FOLD = 2'b11
    } mdh_phase_t;
endpackage
`default_nettype wire

// file: tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, irq_n, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int fail_count = 0;
    int num_checks = 0;
    localparam logic [4:0][31:0] SHA = {32'h9cd0d89d, 32'h7850c26c,
        32'hba3e2571, 32'h4706816a, 32'ha9993e36};
    localparam logic [4:0][31:0] MD5 = {32'h0, 32'h727fe128,
        32'h7d3f96d6, 32'hb04fd23c, 32'h98500190};
    localparam logic [4:0][31:0] MD4 = {32'h0, 32'h9d72a67a,
        32'he80ac15f, 32'h52d821af, 32'h7a0148a4};
    localparam logic [11:0] CT = mdh_pkg::MDH_CTRL_OFS;
    localparam logic [11:0] ST = mdh_pkg::MDH_STAT_OFS;
    initial forever #10 i_clock = ~i_clock;
    mdh_digest_unit uut (.i_clock(i_clock), .i_rst(i_rst), .i_ce(1'b1),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_irq_n(irq_n));
    mdh_host host (.i_clock(i_clock), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
        .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        host.xfer(w, a, d, q, e);
        if (host.hung) begin
            fail_count++;
            test_done();
        end
    endtask
    // Looked at mid-cycle, away from the edge that updates it
    task automatic chk_irq(input logic exp);
        @(negedge i_clock);
        chk(32'(irq_n), 32'(exp));
    endtask
    // Host pads "abc" itself, starting at word zero
    task automatic blk(input logic md, input logic [31:0] x);
        logic [31:0] v;
        for (int i = 0; i < 16; i++) begin
            v = (i == (md ? 14 : 15)) ? 32'h18 : 32'h0;
            if (i == 0) v = md ? 32'h80636261 : 32'h61626380;
            acc(1'b1, 12'(i * 4), v ^ x);
        end
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        q = 32'h0;
        while (q[0] !== 1'b1 && n < 100) begin
            acc(1'b0, ST, 32'h0);
            n++;
        end
        if (q[0] !== 1'b1) begin
            fail_count++;
            test_done();
        end
    endtask
    task automatic chk_dig(input logic [4:0][31:0] x, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            acc(1'b0, mdh_pkg::MDH_DIG_OFS + 12'(i * 4), 32'h0);
            chk(q, x[i]);
        end
    endtask
    initial begin
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        acc(1'b0, CT, 32'h0);
        chk(q, 32'h0);
        acc(1'b0, ST, 32'h0);
        chk(q, 32'h0);
        chk_dig(mdh_pkg::MDH_IV, 5);
        $display("test reset values done");
        acc(1'b1, CT, 32'h10);
        blk(1'b0, 32'h0);
        chk_irq(1'b1);
        acc(1'b1, CT, 32'h18);
        wait_done();
        chk_dig(SHA, 5);
        acc(1'b0, ST, 32'h0);
        chk(q, 32'hb);
        chk_irq(1'b0);
        acc(1'b0, CT, 32'h0);
        chk(q, 32'h10);
        acc(1'b1, CT, 32'h4);
        chk_irq(1'b1);
        acc(1'b0, mdh_pkg::MDH_DIG_OFS, 32'h0);
        chk(q, 32'h363e99a9);
        acc(1'b1, ST, 32'hffffffff);
        acc(1'b0, ST, 32'h0);
        chk(q, 32'h0);
        acc(1'b0, 12'h060, 32'h0);
        chk({q[30:0], e}, 32'h1);
        acc(1'b0, ST, 32'h0);
        chk(q, 32'h4);
        $display("test sha1 go done");
        acc(1'b1, mdh_pkg::MDH_DIG_OFS, 32'h12345678);
        acc(1'b1, CT, 32'h20);
        acc(1'b0, ST, 32'h0);
        chk(q, 32'h0);
        chk_dig(mdh_pkg::MDH_IV, 5);
        acc(1'b1, CT, 32'h990);
        blk(1'b1, 32'h0);
        acc(1'b0, ST, 32'h0);
        chk(q, 32'ha);
        chk_irq(1'b0);
        wait_done();
        chk_dig(MD5, 4);
        acc(1'b1, CT, 32'h20);
        acc(1'b1, CT, 32'h50);
        blk(1'b1, 32'h0);
        acc(1'b1, CT, 32'h58);
        acc(1'b0, ST, 32'h0);
        chk(q, 32'h2);
        chk_irq(1'b1);
        wait_done();
        chk_dig(MD4, 4);
        acc(1'b1, CT, 32'h20);
        $display("test md5 md4 done");
        acc(1'b1, CT, 32'h200);
        blk(1'b0, mdh_pkg::MDH_INNER_PAD_BIT);
        acc(1'b1, CT, 32'h208);
        wait_done();
        chk_dig(SHA, 5);
        acc(1'b0, CT, 32'h0);
        chk(q, 32'h0);
        acc(1'b1, CT, 32'h20);
        acc(1'b1, CT, 32'h200);
        blk(1'b0, mdh_pkg::MDH_INNER_PAD_BIT);
        acc(1'b1, CT, 32'h8);
        blk(1'b0, 32'h0);
        wait_done();
        acc(1'b1, ST, 32'h0);
        wait_done();
        acc(1'b1, CT, 32'h20);
        acc(1'b1, CT, 32'h400);
        blk(1'b0, mdh_pkg::MDH_OUTER_PAD_BIT);
        acc(1'b1, CT, 32'h408);
        wait_done();
        chk_dig(SHA, 5);
        acc(1'b0, CT, 32'h0);
        chk(q, 32'h0);
        acc(1'b1, ST, 32'h0);
        wait_done();
        acc(1'b1, CT, 32'h20);
        $display("test pads and chaining done");
        acc(1'b1, CT, 32'h2);
        repeat (10) acc(1'b1, CT, 32'ha);
        repeat (100) @(posedge i_clock);
        acc(1'b0, ST, 32'h0);
        chk(q, 32'h2);
        acc(1'b1, CT, 32'h20);
        $display("test single step done");
        test_done();
    end
endmodule
`default_nettype wire
